// file: lpm_map.vh
// constants for the lin phy mode controller
`ifndef LPM_MAP_VH
`define LPM_MAP_VH
// clock period in ns and timing figures
`define LPM_CLK_NS 8
`define LPM_GOTONORM_NS 10000
`define LPM_GOTOSLEEP_NS 10000
`define LPM_WAKE_LIN_NS 150000
`define LPM_TXD_TO_MS 90
// cycle counts of the figures above at the 8 ns period, 24 bits wide
`define LPM_GOTONORM_CYC 24'h0004e2
`define LPM_GOTOSLEEP_CYC 24'h0004e2
`define LPM_WAKE_LIN_CYC 24'h00493e
`define LPM_TXD_TO_CYC 24'haba950
// mode encodings
`define LPM_MODE_SLEEP 2'h0
`define LPM_MODE_STANDBY 2'h1
`define LPM_MODE_NORMAL 2'h2
`define LPM_MODE_POWERUP 2'h3
`endif

// file: lpm_pulse_filter.v
// level duration filter: flags a level held longer than a count
`timescale 1ns/1ps
`default_nettype none
module lpm_pulse_filter #(
    parameter [23:0] LIMIT = 24'h000001
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire level_i,
    output reg held_o
);
    reg [23:0] count;

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= 24'h000000;
            held_o <= 1'b0;
        end else if (!level_i) begin
            count <= 24'h000000;
            held_o <= 1'b0;
        end else if (count < LIMIT) begin
            count <= count + 24'h000001;
            held_o <= 1'b0;
        end else begin
            held_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: lpm_lin_phy.v
// lin phy mode controller with wake detection and transmit timeout
// Overview of operation
// - in normal, sleep_request_n low over 10 us enters sleep
// - supply_hold_out floats in sleep and from reset to the first clock, driven high otherwise
// - exactly four modes: sleep, standby, normal, power-up
// - remote wake needs bus dominant longer than 150 us
// - local wake needs sleep_request_n high longer than 10 us
// - wake in sleep goes to standby, supply hold high, rx low while request low
// - request high in standby clears wake flag, drops txd pull-down
// - request high in standby drops rx wake low at once
// - request high over 10 us from standby or power-up enters normal
// - normal passes bus to rx and tx input to bus
// - power-up floats rx, weak tx pull-down, transceiver idle
// - bus traffic at most 20 kbit/s
// - transmitter stops on dominant timeout or overtemperature
// - tx input pulled low only in power-up (weak) and in standby while request low (strong); sleep request has no pull-down
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.vh"
module lpm_lin_phy #(
    parameter [23:0] TXD_TO_CYC = `LPM_TXD_TO_CYC
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire sleep_request_n_i,
    input wire txd_i,
    input wire bus_i,
    input wire overtemp_i,
    input wire shunt_source_a_i,
    input wire shunt_source_b_i,
    output reg bus_drive_dom_o,
    output reg rxd_o,
    output reg rxd_oe_o,
    output reg supply_hold_out_o,
    output reg supply_hold_out_oe_o,
    output reg txd_strong_pd_o,
    output reg txd_weak_pd_o,
    output reg shunt_source_a_o,
    output reg shunt_source_b_o,
    output reg wake_source_remote_o,
    output reg [1:0] mode_o
);

    localparam [1:0] ST_SLEEP = `LPM_MODE_SLEEP;
    localparam [1:0] ST_STANDBY = `LPM_MODE_STANDBY;
    localparam [1:0] ST_NORMAL = `LPM_MODE_NORMAL;
    localparam [1:0] ST_POWERUP = `LPM_MODE_POWERUP;

    // =====================================================
    // input synchronisers
    // =====================================================
    reg [4:0] sync_a;
    reg [4:0] sync_b;
    wire sleep_request_n = sync_b[0];
    wire txd = sync_b[1];
    wire bus_dom = ~sync_b[2];
    wire hot = sync_b[3];
    wire bsm_in = sync_b[4];

    // two flops on every pin input
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_a <= 5'h06; // request low, tx and bus recessive
            sync_b <= 5'h06;
        end else begin
            sync_a <= {shunt_source_a_i, overtemp_i, bus_i,
                       txd_i, sleep_request_n_i};
            sync_b <= sync_a;
        end
    end

    reg bsm_b;
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bsm_b <= 1'b0;
        end else begin
            bsm_b <= shunt_source_b_i;
        end
    end
    reg bsm_b2;
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bsm_b2 <= 1'b0;
        end else begin
            bsm_b2 <= bsm_b;
        end
    end

    // =====================================================
    // duration filters
    // =====================================================
    wire hi_held;
    wire lo_held;
    wire wake_held;
    reg [1:0] mode;
    wire wake_watch = (mode == ST_SLEEP) & bus_dom;

    lpm_pulse_filter #(.LIMIT(`LPM_GOTONORM_CYC)) u_hi (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .level_i(sleep_request_n),
        .held_o(hi_held)
    );
    lpm_pulse_filter #(.LIMIT(`LPM_GOTOSLEEP_CYC)) u_lo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .level_i(~sleep_request_n),
        .held_o(lo_held)
    );
    lpm_pulse_filter #(.LIMIT(`LPM_WAKE_LIN_CYC)) u_wk (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .level_i(wake_watch),
        .held_o(wake_held)
    );

    // =====================================================
    // mode machine
    // =====================================================
    reg wake_flag; // wake request pending, rx held low
    reg sleep_request_n_d;
    reg fell_in_normal; // falling edge seen while normal
    reg [1:0] next_mode;

    always @* begin
        next_mode = mode;
        case (mode)
            ST_SLEEP: begin
                // wake goes to standby at once
                if (wake_held || hi_held) begin
                    next_mode = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (hi_held) begin
                    next_mode = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (lo_held && fell_in_normal) begin
                    next_mode = ST_SLEEP;
                end
            end
            ST_POWERUP: begin
                if (hi_held) begin
                    next_mode = ST_NORMAL;
                end
            end
            default: next_mode = ST_POWERUP;
        endcase
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode <= ST_POWERUP;
            sleep_request_n_d <= 1'b0;
            fell_in_normal <= 1'b0;
            wake_flag <= 1'b0;
            wake_source_remote_o <= 1'b0;
        end else begin
            mode <= next_mode;
            sleep_request_n_d <= sleep_request_n;
            if (mode != ST_NORMAL || sleep_request_n) begin
                fell_in_normal <= 1'b0;
            end else if (sleep_request_n_d) begin
                fell_in_normal <= 1'b1;
            end
            if (mode == ST_SLEEP && (wake_held || hi_held)) begin
                wake_flag <= 1'b1;
                wake_source_remote_o <= wake_held;
            end else if (mode == ST_STANDBY && sleep_request_n) begin
                wake_flag <= 1'b0;
                wake_source_remote_o <= 1'b0;
            end
        end
    end

    // =====================================================
    // transmit dominant timeout
    // =====================================================
    reg [23:0] dom_cnt;
    reg tx_lock;
    // long dominant tx input stops driver
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dom_cnt <= 24'h000000;
            tx_lock <= 1'b0;
        end else if (txd) begin
            dom_cnt <= 24'h000000;
            tx_lock <= 1'b0;
        end else if (dom_cnt < TXD_TO_CYC) begin
            dom_cnt <= dom_cnt + 24'h000001;
        end else begin
            tx_lock <= 1'b1;
        end
    end

    // =====================================================
    // pin outputs
    // =====================================================
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_drive_dom_o <= 1'b0;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
            supply_hold_out_o <= 1'b0;
            supply_hold_out_oe_o <= 1'b0;
            txd_strong_pd_o <= 1'b0;
            txd_weak_pd_o <= 1'b1;
            shunt_source_a_o <= 1'b0;
            shunt_source_b_o <= 1'b0;
            mode_o <= ST_POWERUP;
        end else begin
            mode_o <= next_mode;
            supply_hold_out_o <= (next_mode != ST_SLEEP);
            supply_hold_out_oe_o <= (next_mode != ST_SLEEP);
            // drive bus from tx input in normal
            bus_drive_dom_o <= (next_mode == ST_NORMAL) & ~txd &
                               ~tx_lock & ~hot;
            // power-up floats rx, weak pull-down on tx
            rxd_oe_o <= (next_mode != ST_POWERUP);
            txd_weak_pd_o <= (next_mode == ST_POWERUP);
            // three-cycle rx path, far inside a 20 kbit/s bit
            // wake low released as soon as request high
            if (next_mode == ST_NORMAL) begin
                rxd_o <= ~bus_dom;
            end else if (next_mode == ST_STANDBY) begin
                rxd_o <= ~(wake_flag | (mode == ST_SLEEP)) | sleep_request_n;
            end else begin
                rxd_o <= 1'b1;
            end
            txd_strong_pd_o <= (next_mode == ST_STANDBY) & ~sleep_request_n;
            shunt_source_a_o <= bsm_in;
            shunt_source_b_o <= bsm_b2;
        end
    end
endmodule
`default_nettype wire

// file: lpm_bus_model.sv
// bus model: pulled-up wire that the node or a master pulls dominant
`timescale 1ns/1ps
`default_nettype none
module lpm_bus_model (
    input wire logic node_dom_i,
    input wire logic master_dom_i,
    output logic bus_o
);
    // ==========
    // wired bus, low is dominant, pull-up keeps it recessive when released
    assign bus_o = !(node_dom_i || master_dom_i);
endmodule
`default_nettype wire

// file: lpm_lin_phy_checker.sv
// assertions on the lin phy mode controller ports
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.vh"
module lpm_lin_phy_checker (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic sleep_request_n_i,
    input wire logic bus_i,
    input wire logic rxd_o,
    input wire logic rxd_oe_o,
    input wire logic supply_hold_out_o,
    input wire logic supply_hold_out_oe_o,
    input wire logic [1:0] mode_o
);
    // ==========
    // held-level counters of the raw pins
    logic [16:0] hi, lo, dm;
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi <= 17'h0;
            lo <= 17'h0;
            dm <= 17'h0;
        end else begin
            hi <= sleep_request_n_i ? hi + 17'h1 : 17'h0;
            lo <= sleep_request_n_i ? 17'h0 : lo + 17'h1;
            dm <= bus_i ? 17'h0 : dm + 17'h1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sleep_entry_a: assert property ($changed(mode_o) && mode_o == 2'h0
        |-> $past(mode_o) == 2'h2 && lo >= `LPM_GOTOSLEEP_CYC)
        else $error("early sleep");
    hold_sleep_a: assert property (mode_o == 2'h0 && $past(mode_o) == 2'h0
        |-> !supply_hold_out_oe_o) else $error("hold driven in sleep");
    hold_awake_a: assert property ($past(rstn_i, 2) && mode_o != 2'h0
        && $past(mode_o) != 2'h0 |-> supply_hold_out_oe_o && supply_hold_out_o)
        else $error("hold not high");
    wake_exit_a: assert property ($past(mode_o) == 2'h0 && mode_o != 2'h0
        |-> mode_o == 2'h1 && (dm >= `LPM_WAKE_LIN_CYC
        || hi >= `LPM_GOTONORM_CYC)) else $error("bad wake");
    wake_show_a: assert property ($rose(mode_o == 2'h1) && !sleep_request_n_i
        |-> ##[0:2] !rxd_o && supply_hold_out_o) else $error("wake not shown");
    wake_clear_a: assert property (mode_o == 2'h1 && $rose(sleep_request_n_i)
        |-> ##[1:4] rxd_o) else $error("wake not cleared");
    norm_entry_a: assert property ($rose(mode_o == 2'h2)
        |-> hi >= `LPM_GOTONORM_CYC) else $error("early normal");
    rx_follow_a: assert property ((mode_o == 2'h2 && $stable(bus_i)) [*6]
        |-> rxd_o == bus_i && rxd_oe_o) else $error("rxd not bus");
endmodule
bind lpm_lin_phy lpm_lin_phy_checker lpm_lin_phy_checker_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
    .sleep_request_n_i(sleep_request_n_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
    .supply_hold_out_o(supply_hold_out_o), .mode_o(mode_o),
    .supply_hold_out_oe_o(supply_hold_out_oe_o));
`default_nettype wire

// file: lpm_lin_phy_test.sv
// self-checking bench for the lin phy mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_lin_phy_test;
    // ==========
    // stimulus, instances and scenarios
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, req_n = 1'b0, txd = 1'b1;
    logic mdom = 1'b0, ot = 1'b0, sa = 1'b0, sb = 1'b0;
    wire bus, drv, rxd, rxd_oe, sho, sho_oe, spd, wpd, soa, sob, wsr;
    wire [1:0] mode;
    int n_errors = 0, comparisons = 0;
    lpm_bus_model lpm_bus_model_inst (.node_dom_i(drv), .master_dom_i(mdom),
        .bus_o(bus));
    lpm_lin_phy #(.TXD_TO_CYC(24'h000064)) lpm_lin_phy_inst (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sleep_request_n_i(req_n),
        .txd_i(txd), .bus_i(bus), .overtemp_i(ot), .shunt_source_a_i(sa),
        .shunt_source_b_i(sb), .bus_drive_dom_o(drv), .rxd_o(rxd),
        .rxd_oe_o(rxd_oe), .supply_hold_out_o(sho),
        .supply_hold_out_oe_o(sho_oe), .txd_strong_pd_o(spd),
        .txd_weak_pd_o(wpd), .shunt_source_a_o(soa), .shunt_source_b_o(sob),
        .wake_source_remote_o(wsr), .mode_o(mode));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // bounded wait for a mode, a miss ends the run
    task automatic wait_mode(input logic [1:0] m, input int lim);
        int k;
        for (k = 0; k < lim && mode !== m; k++)
            @(posedge sys_clk_i);
        chk({1'b0, mode}, {1'b0, m});
        if (mode !== m)
            complete_run();
    endtask
    task automatic t_power_up();
        chk({1'b0, mode}, 3'h3);
        chk({rxd_oe, wpd, drv}, 3'b010);
        req_n <= 1'b1;
        cyc(1000);
        req_n <= 1'b0;
        cyc(5);
        req_n <= 1'b1;
        cyc(1200);
        chk({1'b0, mode}, 3'h3);
        wait_mode(2'h2, 200);
        chk({1'b0, sho, sho_oe}, 3'b011);
    endtask
    task automatic t_traffic();
        // short levels only exercise the path, block has no rate
        mdom <= 1'b1;
        cyc(6);
        chk({1'b0, rxd, drv}, 3'b000);
        mdom <= 1'b0;
        txd <= 1'b0;
        cyc(6);
        chk({1'b0, bus, drv}, 3'b001);
        cyc(110);
        chk({2'b00, drv}, 3'b000);
        txd <= 1'b1;
        cyc(6);
        txd <= 1'b0;
        cyc(6);
        chk({2'b00, drv}, 3'b001);
        ot <= 1'b1;
        cyc(10);
        chk({1'b0, rxd, drv}, 3'b010);
        txd <= 1'b1;
        ot <= 1'b0;
    endtask
    // background, source a alone, both, then both off
    // all steps fit one break field
    // address acceptance stays with controller software
    task automatic t_shunt();
        logic [1:0] step [4] = '{2'b00, 2'b10, 2'b11, 2'b00};
        for (int k = 0; k < 4; k++) begin
            {sa, sb} <= step[k];
            cyc(4);
            chk({1'b0, soa, sob}, {1'b0, step[k]});
        end
    endtask
    task automatic t_sleep();
        // supply hold is never pulled low here, so sleep is allowed
        req_n <= 1'b0;
        cyc(1200);
        chk({1'b0, mode}, 3'h2);
        wait_mode(2'h0, 200);
        cyc(2);
        chk({2'b00, sho_oe}, 3'h0);
    endtask
    task automatic t_remote();
        mdom <= 1'b1;
        cyc(18000);
        chk({1'b0, mode}, 3'h0);
        wait_mode(2'h1, 1000);
        mdom <= 1'b0;
        cyc(3);
        chk({rxd, sho, wsr}, 3'b011);
        chk({spd, wpd, rxd_oe}, 3'b101);
        req_n <= 1'b1;
        cyc(4);
        chk({rxd, spd, wsr}, 3'b100);
        wait_mode(2'h2, 1400);
    endtask
    task automatic t_local();
        req_n <= 1'b0;
        wait_mode(2'h0, 1400);
        req_n <= 1'b1;
        cyc(1200);
        chk({1'b0, mode}, 3'h0);
        wait_mode(2'h1, 200);
        wait_mode(2'h2, 1400);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(4);
        rstn_i <= 1'b1;
        cyc(3);
        t_power_up();
        t_traffic();
        t_shunt();
        t_sleep();
        t_remote();
        t_local();
        complete_run();
    end
endmodule
`default_nettype wire
